// >>> hw/necc_defines.svh
// nand ecc upper status block: constants and behaviour summary
// What this block does
// - eight flag nibbles, sectors 8..15, each 256 bytes of bytes 2048..4095
// - all upper sector flags read zero while correction type is whole-page
// - recoverable flag set on a single or multiple sector error, not on a code byte error alone; multi flag tells which
// - code byte flag set when one bit error lies in stored code bytes
// - code byte error marks its position by a one in low 24 bits
// - multi error flag set on several errors, cleared otherwise
// - whole-page single error puts bit offset in bit location field
// - on multiple page errors location fields are meaningless
// - whole-page word location counts 8 or 16 bit words per organisation
// - correction type 01 means one code per 256 bytes, sector flags live
`ifndef NECC_DEFINES_SVH
`define NECC_DEFINES_SVH
`define NECC_AW 8
`define NECC_OFF_SR 8'h00
`define NECC_OFF_LOC 8'h04
`define NECC_OFF_PAR 8'h08
`define NECC_OFF_ISTS 8'h0c
`define NECC_OFF_IMSK 8'h10
`define NECC_MARK_SEL 3'h1
`define NECC_CT_PAGE 2'h0
`define NECC_CT_SECTOR 2'h1
`define NECC_NIB_REC 0
`define NECC_NIB_CODE 1
`define NECC_NIB_MUL 2
`define NECC_NIB_W 4
`define NECC_MARK_W 24
`define NECC_LOC_WORD_LSB 4
`define NECC_EV_SINGLE 0
`define NECC_EV_MULTI 1
`define NECC_EV_CODE 2
`define NECC_EV_PAGE 3
`define NECC_EV_W 4
`define NECC_RESP_OKAY 2'h0
`define NECC_RESP_SLVERR 2'h2
`endif

// >>> hw/necc_pkg.sv
// nand ecc upper status block: types
`default_nettype none
package necc_pkg;
  typedef logic [7:0][2:0] necc_sec_flags_t;
  typedef logic [7:0][23:0] necc_marks_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    necc_sec_flags_t sec;
    necc_marks_t mark;
    logic [3:0] bit_location;
    logic [11:0] word_location;
    logic [15:0] computed_parity;
    logic [3:0] irq_sts;
    logic [3:0] irq_mask;
    logic irq;
  } necc_state_t;
endpackage
`default_nettype wire

// >>> hw/necc_top.sv
// nand ecc upper sector status, page location and parity over axi4-lite
`include "necc_defines.svh"
`default_nettype none
module necc_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // configuration from mode register
  input wire logic [1:0] correction_type,
  input wire logic bus_16bit,
  // per-sector result from ecc engine
  input wire logic sec_done,
  input wire logic [2:0] sec_index,
  input wire logic sec_single,
  input wire logic sec_multi,
  input wire logic sec_code_byte,
  input wire logic [4:0] sec_code_pos,
  // whole-page result from ecc engine
  input wire logic page_done,
  input wire logic page_is_read,
  input wire logic page_single,
  input wire logic page_multi,
  input wire logic [11:0] page_err_byte,
  input wire logic [2:0] page_err_bit,
  input wire logic [15:0] computed_parity,
  // interrupt
  output logic irq
);

  necc_pkg::necc_state_t r;
  necc_pkg::necc_state_t n;

  function automatic logic [23:0] pos_mark(input logic [4:0] pos);
    // positions past the code width give no mark
    pos_mark = (pos < 5'h18) ? (24'h000001 << pos) : 24'h000000;
  endfunction

  function automatic logic [31:0] status_word(
      input necc_pkg::necc_sec_flags_t f, input logic [1:0] ct);
    logic [31:0] w;
    w = 32'h00000000;
    if (ct == `NECC_CT_SECTOR) begin
      for (int i = 0; i < 8; i++) begin
        w[i*`NECC_NIB_W +: 3] = f[i];
      end
    end
    status_word = w;
  endfunction

  function automatic logic [33:0] read_word(
      input necc_pkg::necc_state_t s, input logic [7:0] a,
      input logic [1:0] ct);
    logic [31:0] d;
    logic ok;
    d = 32'h00000000;
    ok = 1'b1;
    if (a[7:5] == `NECC_MARK_SEL && a[1:0] == 2'h0) begin
      d[23:0] = s.mark[a[4:2]];
    end else begin
      unique case (a)
        `NECC_OFF_SR: d = status_word(s.sec, ct);
        `NECC_OFF_LOC: begin
          d[3:0] = s.bit_location;
          d[`NECC_LOC_WORD_LSB +: 12] = s.word_location;
        end
        `NECC_OFF_PAR: d[15:0] = s.computed_parity;
        `NECC_OFF_ISTS: d[3:0] = s.irq_sts;
        `NECC_OFF_IMSK: d[3:0] = s.irq_mask;
        default: ok = 1'b0;
      endcase
    end
    read_word = {ok, 1'b0, d};
  endfunction

  logic [3:0] ev;
  logic [3:0] clr;
  logic [33:0] rd;
  logic [33:0] wr_rd;
  logic wr_ok;

  always_comb begin
    n = r;
    ev = 4'h0;
    clr = 4'h0;
    rd = 34'h0;
    wr_rd = 34'h0;
    wr_ok = 1'b0;

    // write address and data taken in either order
    if (s_axi_awvalid && r.awready) begin
      n.aw_held = 1'b1;
      n.awaddr = s_axi_awaddr;
      n.awready = 1'b0;
    end
    if (s_axi_wvalid && r.wready) begin
      n.w_held = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
      n.wready = 1'b0;
    end
    if (r.aw_held && r.w_held && !r.bvalid) begin
      // read-only registers take writes silently
      wr_rd = read_word(r, r.awaddr, correction_type);
      wr_ok = wr_rd[33];
      if (r.awaddr == `NECC_OFF_ISTS && r.wstrb[0]) begin
        clr = r.wdata[3:0];
      end
      if (r.awaddr == `NECC_OFF_IMSK && r.wstrb[0]) begin
        n.irq_mask = r.wdata[3:0];
      end
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = wr_ok ? `NECC_RESP_OKAY : `NECC_RESP_SLVERR;
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
      n.awready = 1'b1;
      n.wready = 1'b1;
    end

    // read: data sampled at the address handshake
    if (s_axi_arvalid && r.arready) begin
      rd = read_word(r, s_axi_araddr, correction_type);
      n.rdata = rd[31:0];
      n.rresp = rd[33] ? `NECC_RESP_OKAY : `NECC_RESP_SLVERR;
      n.rvalid = 1'b1;
      n.arready = 1'b0;
    end
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end

    // sector result overwrites the whole nibble, so stale flags clear
    if (sec_done && correction_type == `NECC_CT_SECTOR) begin
      n.sec[sec_index][`NECC_NIB_REC] = sec_single | sec_multi;
      n.sec[sec_index][`NECC_NIB_CODE] = sec_code_byte;
      n.sec[sec_index][`NECC_NIB_MUL] = sec_multi;
      if (sec_code_byte) begin
        n.mark[sec_index] = pos_mark(sec_code_pos);
      end
      ev[`NECC_EV_SINGLE] = sec_single & ~sec_multi;
      ev[`NECC_EV_MULTI] = sec_multi;
      ev[`NECC_EV_CODE] = sec_code_byte;
    end

    if (page_done && correction_type == `NECC_CT_PAGE) begin
      if (page_is_read) begin
        // multiple errors leave location fields as they were
        if (page_single && !page_multi) begin
          if (bus_16bit) begin
            n.bit_location = {page_err_byte[0], page_err_bit};
            n.word_location = {1'b0, page_err_byte[11:1]};
          end else begin
            n.bit_location = {1'b0, page_err_bit};
            n.word_location = page_err_byte;
          end
        end
        ev[`NECC_EV_PAGE] = page_single | page_multi;
      end else begin
        n.computed_parity = computed_parity;
      end
    end

    // a new event wins over a clear in the same cycle
    n.irq_sts = (r.irq_sts & ~clr) | ev;
    n.irq = |(n.irq_sts & n.irq_mask);

    if (!aresetn) begin
      n = '0;
      n.awready = 1'b1;
      n.wready = 1'b1;
      n.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    r <= n;
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bresp = r.bresp;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_arready = r.arready;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rvalid = r.rvalid;
  assign irq = r.irq;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence sec_result;
    sec_done && correction_type == `NECC_CT_SECTOR;
  endsequence

  sequence page_single_read;
    page_done && page_is_read && page_single && !page_multi &&
      correction_type == `NECC_CT_PAGE;
  endsequence

  a_page_mode_zero: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `NECC_OFF_SR &&
      correction_type != `NECC_CT_SECTOR |=> s_axi_rdata == 32'h00000000)
    else $error("sector flags not zero outside sector mode");

  a_rec_flag_set: assert property (
    sec_result ##0 (sec_single || sec_multi) |=>
      r.sec[$past(sec_index)][`NECC_NIB_REC])
    else $error("recoverable flag not set");

  a_code_flag: assert property (
    sec_result |=> r.sec[$past(sec_index)][`NECC_NIB_CODE] ==
      $past(sec_code_byte))
    else $error("code byte flag wrong");

  a_code_mark: assert property (
    sec_result ##0 (sec_code_byte && sec_code_pos < 5'h18) |=>
      r.mark[$past(sec_index)] == (24'h000001 << $past(sec_code_pos)))
    else $error("code byte mark wrong");

  a_multi_flag: assert property (
    sec_result |=> r.sec[$past(sec_index)][`NECC_NIB_MUL] ==
      $past(sec_multi))
    else $error("multi error flag wrong");

  a_bit_loc_8: assert property (
    page_single_read ##0 !bus_16bit |=>
      r.bit_location == {1'b0, $past(page_err_bit)} &&
      r.word_location == $past(page_err_byte))
    else $error("8-bit location wrong");

  a_word_loc_16: assert property (
    page_single_read ##0 bus_16bit |=>
      r.word_location == {1'b0, $past(page_err_byte[11:1])} &&
      r.bit_location[3] == $past(page_err_byte[0]))
    else $error("16-bit location wrong");

  a_parity_keep: assert property (
    page_done && !page_is_read && correction_type == `NECC_CT_PAGE |=>
      r.computed_parity == $past(computed_parity))
    else $error("parity not captured");

  a_nibble_top: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `NECC_OFF_SR |=>
      (s_axi_rdata & 32'h88888888) == 32'h00000000)
    else $error("reserved status bit set");

  a_multi_keeps_loc: assert property (
    page_done && page_is_read && page_multi &&
      correction_type == `NECC_CT_PAGE |=>
      $stable(r.bit_location) && $stable(r.word_location))
    else $error("location changed on multiple errors");

  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");

  a_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data not held");

  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  a_write_answer: assert property (
    both_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response missing");

  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");

  // irq must follow the registered status and mask, never a cycle stale
  a_irq_level: assert property (
    irq == |(r.irq_sts & r.irq_mask))
    else $error("interrupt level wrong");

  a_event_sticky: assert property (
    sec_result ##0 sec_multi |=> r.irq_sts[`NECC_EV_MULTI])
    else $error("event lost against a clear");

endmodule
`default_nettype wire

// >>> dv/necc_top_tb.sv
// self-checking bench for the nand ecc upper status block
`default_nettype none
module necc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, bus_16bit, sec_done, sec_single;
  logic sec_multi, sec_code_byte, page_done, page_is_read, page_single;
  logic page_multi, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, correction_type, rsp;
  logic [2:0] sec_index, page_err_bit;
  logic [4:0] sec_code_pos;
  logic [11:0] page_err_byte;
  logic [15:0] computed_parity;
  int err_count = 0;
  int compares = 0;

  always #12.5 aclk = ~aclk;

  necc_top necc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .correction_type,
    .bus_16bit, .sec_done, .sec_index, .sec_single, .sec_multi,
    .sec_code_byte, .sec_code_pos, .page_done, .page_is_read,
    .page_single, .page_multi, .page_err_byte, .page_err_bit,
    .computed_parity, .irq);

  task automatic chk(input string nm, input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    chk(nm, rd, exp);
    chk(nm, {30'h0, rsp}, {30'h0, er});
  endtask

  task automatic sc(input logic [2:0] i, input logic s, m, c,
                    input logic [4:0] p);
    @(posedge aclk);
    sec_done <= 1'h1;
    sec_index <= i;
    sec_single <= s;
    sec_multi <= m;
    sec_code_byte <= c;
    sec_code_pos <= p;
    @(posedge aclk);
    sec_done <= 1'h0;
  endtask

  task automatic pg(input logic r, s, m, input logic [11:0] b,
                    input logic [2:0] t, input logic [15:0] par);
    @(posedge aclk);
    page_done <= 1'h1;
    page_is_read <= r;
    page_single <= s;
    page_multi <= m;
    page_err_byte <= b;
    page_err_bit <= t;
    computed_parity <= par;
    @(posedge aclk);
    page_done <= 1'h0;
  endtask

  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid,
     s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready,
     correction_type, bus_16bit, sec_done, sec_index, sec_single,
     sec_multi, sec_code_byte, sec_code_pos, page_done, page_is_read,
     page_single, page_multi, page_err_byte, page_err_bit,
     computed_parity} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    for (int k = 0; k < 5; k++)
      rchk("reset", 8'(k * 4), 32'h0, 2'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    $display("test reset done");
    correction_type <= 2'h1;
    for (int i = 0; i < 8; i++)
      sc(3'(i), i % 2 == 0, i % 2 == 1, 1'h0, 5'h0);
    // whole nibble is rewritten, so sector 10 loses its single flag
    sc(3'h2, 1'h0, 1'h0, 1'h1, 5'h17);
    rchk("status", 8'h00, 32'h51515251, 2'h0);
    rchk("mark", 8'h28, 32'h00800000, 2'h0);
    rchk("irq_sts", 8'h0c, 32'h7, 2'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(8'h10, 32'h2);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(8'h0c, 32'h2);
    chk("irq", {31'h0, irq}, 32'h0);
    rchk("irq_sts", 8'h0c, 32'h5, 2'h0);
    sc(3'h1, 1'h1, 1'h0, 1'h0, 5'h0);
    rchk("status", 8'h00, 32'h51515211, 2'h0);
    $display("test sector flags done");
    correction_type <= 2'h0;
    rchk("status", 8'h00, 32'h0, 2'h0);
    // ignored outside sector mode
    sc(3'h0, 1'h0, 1'h1, 1'h0, 5'h0);
    pg(1'h0, 1'h0, 1'h0, 12'h0, 3'h0, 16'hbeef);
    rchk("parity", 8'h08, 32'h0000beef, 2'h0);
    pg(1'h1, 1'h1, 1'h0, 12'h5a3, 3'h5, 16'h0);
    rchk("loc8", 8'h04, {16'h0, 12'h5a3, 4'h5}, 2'h0);
    bus_16bit <= 1'h1;
    pg(1'h1, 1'h1, 1'h0, 12'h5a3, 3'h6, 16'h0);
    rchk("loc16", 8'h04, {16'h0, 12'h2d1, 4'he}, 2'h0);
    rchk("irq_sts", 8'h0c, 32'hd, 2'h0);
    // multiple errors leave the location alone but still raise the event
    wr(8'h0c, 32'h8);
    pg(1'h1, 1'h0, 1'h1, 12'h123, 3'h1, 16'h0);
    rchk("loc_multi", 8'h04, {16'h0, 12'h2d1, 4'he}, 2'h0);
    rchk("irq_page", 8'h0c, 32'hd, 2'h0);
    correction_type <= 2'h1;
    rchk("status", 8'h00, 32'h51515211, 2'h0);
    $display("test page mode done");
    wr(8'h00, 32'hffffffff);
    chk("bresp_ro", {30'h0, rsp}, 32'h0);
    rchk("status", 8'h00, 32'h51515211, 2'h0);
    wr(8'h14, 32'h0);
    chk("bresp_bad", {30'h0, rsp}, 32'h2);
    rchk("unmapped", 8'h14, 32'h0, 2'h2);
    $display("test bus access done");
    complete_run;
  end

  initial begin
    repeat (5000) @(posedge aclk);
    err_count++;
    complete_run;
  end
endmodule
`default_nettype wire
